// ### rtl/gpf_pkg.sv
// constants shared by the gpio port logic: address map, reset defaults, pin maps
package gpf_pkg;
	localparam int          NPORT     = 8;
	localparam int          PW        = 8;
	localparam int          ADDR_W    = 15;
	localparam int          OFF_W     = 12;
	localparam int          PORT_LSB  = 12;
	localparam int          MASK_LSB  = 2;
	localparam logic [11:0] OFF_DLIM  = 12'h400;
	localparam logic [11:0] OFF_DIR   = 12'h400;
	localparam logic [11:0] OFF_IS    = 12'h404;
	localparam logic [11:0] OFF_IBE   = 12'h408;
	localparam logic [11:0] OFF_IEV   = 12'h40C;
	localparam logic [11:0] OFF_IM    = 12'h410;
	localparam logic [11:0] OFF_RIS   = 12'h414;
	localparam logic [11:0] OFF_MIS   = 12'h418;
	localparam logic [11:0] OFF_AFSEL = 12'h420;
	localparam logic [11:0] OFF_PUR   = 12'h510;
	localparam logic [11:0] OFF_PDR   = 12'h514;
	localparam logic [11:0] OFF_DEN   = 12'h51C;
	localparam logic [11:0] OFF_ANALOG_MODE_BIT = 12'h528;
	localparam logic [11:0] OFF_PCTL  = 12'h52C;
	// per-port tables, index 0 is port A
	localparam logic [7:0][7:0]  PIN_MASK = {8'h03, 8'h03, 8'h0F, 8'h0F,
		8'hFF, 8'h7F, 8'hFF, 8'hFF};
	localparam logic [7:0][7:0]  AFSEL_RST = {8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h0F, 8'h0C, 8'h3F};
	localparam logic [7:0][7:0]  DEN_RST   = {8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h0F, 8'h0C, 8'h3F};
	localparam logic [7:0][7:0]  PUR_RST   = {8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h0F, 8'h00, 8'h00};
	localparam logic [7:0][31:0] PCTL_RST  = {32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h00003333, 32'h00001100, 32'h00111111};
	localparam logic [7:0][31:0] FUNC_CODE = {{5{32'h11111111}}, 32'h11113333,
		32'h11111111, 32'h11111111};
	localparam logic [7:0][7:0]  CMP_MASK  = {8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h50, 8'h00};
	localparam int          TRIG_PORT = 1;
	localparam int          TRIG_BIT  = 4;
endpackage

// ### rtl/gpf_port.sv
// one gpio port: pin registers, function routing, interrupt sensing
`timescale 1ns/1ps
`default_nettype none
module gpf_port #(
	parameter logic [7:0]  PM      = 8'hFF,
	parameter logic [7:0]  AF_RST  = 8'h00,
	parameter logic [7:0]  DEN_RST = 8'h00,
	parameter logic [7:0]  PU_RST  = 8'h00,
	parameter logic [31:0] PC_RST  = 32'h0,
	parameter logic [31:0] FCODE   = 32'h11111111,
	parameter logic [7:0]  CMASK   = 8'h00,
	parameter bit          TRIG_EN = 1'b0
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      sel,
	input  wire logic [gpf_pkg::OFF_W-1:0] off,
	input  wire logic [31:0]               wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [31:0]               rd_val,
	input  wire logic [7:0]                pin,
	output logic      [7:0]                pin_out,
	output logic      [7:0]                pin_oe,
	output logic      [7:0]                pull_up,
	output logic      [7:0]                pull_down,
	input  wire logic [7:0]                alt_out,
	input  wire logic [7:0]                alt_oe,
	output logic      [7:0]                alt_in,
	output logic      [7:0]                ana_en,
	output logic      [7:0]                cmp_en,
	output logic                           irq,
	output logic                           trig
);
	import gpf_pkg::*;
	typedef struct packed {
		logic [7:0]  dir, data, afsel, digital_enable_bit, pdr, pur, analog_mode_bit;
		logic [31:0] pctl;
		logic [7:0]  is, ibe, iev, im, ris, prev;
		logic [7:0]  pout, poe, ain, ana, cmp;
		logic        irq, trig;
	} gpf_port_s;
	gpf_port_s  s_r;
	gpf_port_s  s_nxt;
	logic [7:0] alt_sel, m, rise, fall, cond, wd;
	logic       isdat;

	// per-pin alternate connect: each pin looks only at its own bits
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			alt_sel[i] = s_r.afsel[i] & s_r.digital_enable_bit[i]
				& (s_r.pctl[4*i +: 4] == FCODE[4*i +: 4]);
		end
	end

	// address mask and interrupt conditions
	always_comb begin
		m     = off[MASK_LSB +: 8];
		isdat = off < OFF_DLIM;
		wd    = wdata[7:0];
		rise  = pin & ~s_r.prev;
		fall  = ~pin & s_r.prev;
		cond  = PM & ((s_r.is & ~(s_r.iev ^ pin))
			| (~s_r.is & ((s_r.ibe & (rise | fall))
			| (~s_r.ibe & ((s_r.iev & rise) | (~s_r.iev & fall))))));
	end

	// next state: register writes, status, pin drive
	always_comb begin
		s_nxt      = s_r;
		s_nxt.prev = pin;
		if (wr && sel) begin
			if (isdat) begin
				s_nxt.data = ((s_r.data & ~m) | (wd & m)) & PM;
			end else if (off == OFF_DIR) begin
				s_nxt.dir = wd & PM;
			end else if (off == OFF_IS) begin
				s_nxt.is = wd & PM;
			end else if (off == OFF_IBE) begin
				s_nxt.ibe = wd & PM;
			end else if (off == OFF_IEV) begin
				s_nxt.iev = wd & PM;
			end else if (off == OFF_IM) begin
				s_nxt.im = wd & PM;
			end else if (off == OFF_AFSEL) begin
				s_nxt.afsel = wd & PM;
			end else if (off == OFF_PUR) begin
				s_nxt.pur = wd & PM;
			end else if (off == OFF_PDR) begin
				s_nxt.pdr = wd & PM;
			end else if (off == OFF_DEN) begin
				s_nxt.digital_enable_bit = wd & PM;
			end else if (off == OFF_ANALOG_MODE_BIT) begin
				s_nxt.analog_mode_bit = wd & PM;
			end else if (off == OFF_PCTL) begin
				s_nxt.pctl = wdata;
			end
		end
		// sticky status, read clears, a new event wins over the clear
		if (rd && sel && off == OFF_RIS) begin
			s_nxt.ris = cond;
		end else begin
			s_nxt.ris = s_r.ris | cond;
		end
		s_nxt.irq  = |(s_nxt.ris & s_nxt.im);
		s_nxt.trig = TRIG_EN & cond[TRIG_BIT] & ~s_r.ris[TRIG_BIT]
			& s_r.im[TRIG_BIT];
		s_nxt.pout = (alt_sel & alt_out) | (~alt_sel & s_r.data);
		s_nxt.poe  = PM & ((alt_sel & alt_oe) | (~alt_sel & s_r.digital_enable_bit & s_r.dir));
		s_nxt.ain  = pin & alt_sel;
		s_nxt.ana  = PM & ~s_r.digital_enable_bit & s_r.analog_mode_bit;
		s_nxt.cmp  = CMASK & ~s_r.digital_enable_bit;
	end

	// read value, address-masked for the data window
	always_comb begin
		rd_val = '0;
		if (isdat) begin
			rd_val[7:0] = ((s_r.dir & s_r.data) | (~s_r.dir & pin)) & m & PM;
		end else if (off == OFF_DIR) begin
			rd_val[7:0] = s_r.dir;
		end else if (off == OFF_IS) begin
			rd_val[7:0] = s_r.is;
		end else if (off == OFF_IBE) begin
			rd_val[7:0] = s_r.ibe;
		end else if (off == OFF_IEV) begin
			rd_val[7:0] = s_r.iev;
		end else if (off == OFF_IM) begin
			rd_val[7:0] = s_r.im;
		end else if (off == OFF_RIS) begin
			rd_val[7:0] = s_r.ris;
		end else if (off == OFF_MIS) begin
			rd_val[7:0] = s_r.ris & s_r.im;
		end else if (off == OFF_AFSEL) begin
			rd_val[7:0] = s_r.afsel;
		end else if (off == OFF_PUR) begin
			rd_val[7:0] = s_r.pur;
		end else if (off == OFF_PDR) begin
			rd_val[7:0] = s_r.pdr;
		end else if (off == OFF_DEN) begin
			rd_val[7:0] = s_r.digital_enable_bit;
		end else if (off == OFF_ANALOG_MODE_BIT) begin
			rd_val[7:0] = s_r.analog_mode_bit;
		end else if (off == OFF_PCTL) begin
			rd_val = s_r.pctl;
		end
	end

	// state register, defaults loaded while reset is low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r       <= '0;
			s_r.afsel <= AF_RST;
			s_r.digital_enable_bit   <= DEN_RST;
			s_r.pur   <= PU_RST;
			s_r.pctl  <= PC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_out   = s_r.pout;
	assign pin_oe    = s_r.poe;
	assign pull_up   = s_r.pur;
	assign pull_down = s_r.pdr;
	assign alt_in    = s_r.ain;
	assign ana_en    = s_r.ana;
	assign cmp_en    = s_r.cmp;
	assign irq       = s_r.irq;
	assign trig      = s_r.trig;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rst_def;
		$past(!rst_n) |-> s_r.afsel == AF_RST && s_r.digital_enable_bit == DEN_RST
			&& s_r.pur == PU_RST && s_r.pdr == 8'h00 && s_r.pctl == PC_RST;
	endproperty
	a_rst_def: assert property (p_rst_def) else $error("reset defaults wrong");
	property p_alt_route;
		1 |=> ((pin_out ^ $past(alt_out)) & $past(alt_sel)) == 8'h00;
	endproperty
	a_alt_route: assert property (p_alt_route) else $error("alt output not routed");
	property p_ana;
		1 |=> ana_en == (PM & ~$past(s_r.digital_enable_bit) & $past(s_r.analog_mode_bit));
	endproperty
	a_ana: assert property (p_ana) else $error("analog path enable wrong");
	property p_cmp;
		1 |=> cmp_en == (CMASK & ~$past(s_r.digital_enable_bit));
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator enable wrong");
	property p_wmask;
		wr && sel && isdat |=> ((s_r.data ^ $past(s_r.data)) & ~$past(m)) == 8'h00
			&& ((s_r.data ^ $past(wd)) & $past(m) & PM) == 8'h00;
	endproperty
	a_wmask: assert property (p_wmask) else $error("masked data write wrong");
	property p_rmask;
		rd && sel && isdat |-> (rd_val[7:0] & ~m) == 8'h00 && rd_val[31:8] == 24'h0;
	endproperty
	a_rmask: assert property (p_rmask) else $error("masked data read wrong");
	property p_irq;
		1 |=> irq == |($past(s_nxt.ris) & $past(s_nxt.im));
	endproperty
	a_irq: assert property (p_irq) else $error("port interrupt wrong");
	property p_rise;
		1 |=> ($past(rise & ~s_r.is & ~s_r.ibe & s_r.iev & PM) & ~s_r.ris) == 8'h00;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge not latched");
	property p_trig;
		trig |-> $past(s_r.im[TRIG_BIT]) && s_r.ris[TRIG_BIT] && TRIG_EN;
	endproperty
	a_trig: assert property (p_trig) else $error("converter trigger unexpected");
	sequence s_dwrite;
		wr && sel && isdat && (m & s_r.dir & s_r.digital_enable_bit & ~alt_sel) != 8'h00;
	endsequence
	property p_toggle;
		s_dwrite |-> ##2 ((pin_out ^ $past(wd, 2)) & $past(m & s_r.dir & s_r.digital_enable_bit
			& ~alt_sel, 2) & PM) == 8'h00 || $past(wr, 1);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not follow write");
endmodule // gpf_port
`default_nettype wire

// ### rtl/gpf_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpf_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpf_sync_s;
	gpf_sync_s s_r;
	gpf_sync_s s_nxt;

	// first stage feeds only the second
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule // gpf_sync
`default_nettype wire

// ### rtl/gpio_pin_function_select.sv
// top of the eight-port gpio block: pin sync, port array, register read
//
// Notes on behaviour
// - pins not listed come up plain gpio, tri-stated, all config zero.
// - reset returns every pin setting, exceptions too, to defaults.
// - A[1:0], A[5:2], B[3:2] default alt code 1; C[3:0] code 3 pull-up.
// - alternate function connects only with afsel, den and matching code.
// - each pin configured only by its own bits and field.
// - isolated analog path needs digital enable clear and analog mode set.
// - comparator inputs selected by clearing digital enable.
// - eight identical port instances, A through H.
// - output pin can change every two clock cycles.
// - each pin routes its one alternate function by the pin map.
// - interrupt sense: rising, falling, both edges, high or low level.
// - interrupt reaches output only when its mask bit is set.
// - data reads and writes masked per bit by address lines.
// - gpio interrupt condition can start a converter sample sequence.
// - mask from address bits 9:2; masked write unchanged, masked read zero.
// - each port merges its pin conditions into one interrupt output.
// - unmasked port B bit 4 interrupt also pulses the converter trigger.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_select (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [gpf_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]                wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output logic      [31:0]                rdata,
	input  wire logic [63:0]                pin_in,
	output logic      [63:0]                pin_out,
	output logic      [63:0]                pin_oe,
	output logic      [63:0]                pull_up,
	output logic      [63:0]                pull_down,
	input  wire logic [63:0]                alt_out,
	input  wire logic [63:0]                alt_oe,
	output logic      [63:0]                alt_in,
	output logic      [63:0]                ana_en,
	output logic      [63:0]                cmp_en,
	output logic      [7:0]                 port_irq,
	output logic                            adc_trig
);
	import gpf_pkg::*;
	typedef struct packed {
		logic [31:0] rdata;
	} gpf_top_s;
	gpf_top_s         s_r;
	gpf_top_s         s_nxt;
	logic [63:0]      pin_s;
	logic [7:0]       trig;
	logic [7:0][31:0] rv;
	logic [2:0]       psel;

	// pins cross in through two flops before any logic sees them
	gpf_sync #(.W(64)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (pin_in),
		.q     (pin_s)
	);

	assign psel = addr[PORT_LSB +: 3];

	// eight identical ports, each with its own defaults and function map
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		gpf_port #(
			.PM      (PIN_MASK[p]),
			.AF_RST  (AFSEL_RST[p]),
			.DEN_RST (DEN_RST[p]),
			.PU_RST  (PUR_RST[p]),
			.PC_RST  (PCTL_RST[p]),
			.FCODE   (FUNC_CODE[p]),
			.CMASK   (CMP_MASK[p]),
			.TRIG_EN (p == TRIG_PORT)
		) u_port (
			.clk       (clk),
			.rst_n     (rst_n),
			.sel       (psel == 3'(p)),
			.off       (addr[OFF_W-1:0]),
			.wdata     (wdata),
			.wr        (wr),
			.rd        (rd),
			.rd_val    (rv[p]),
			.pin       (pin_s[PW*p +: PW]),
			.pin_out   (pin_out[PW*p +: PW]),
			.pin_oe    (pin_oe[PW*p +: PW]),
			.pull_up   (pull_up[PW*p +: PW]),
			.pull_down (pull_down[PW*p +: PW]),
			.alt_out   (alt_out[PW*p +: PW]),
			.alt_oe    (alt_oe[PW*p +: PW]),
			.alt_in    (alt_in[PW*p +: PW]),
			.ana_en    (ana_en[PW*p +: PW]),
			.cmp_en    (cmp_en[PW*p +: PW]),
			.irq       (port_irq[p]),
			.trig      (trig[p])
		);
	end

	assign adc_trig = trig[TRIG_PORT];

	// read data registered one cycle after the strobe, zero otherwise
	always_comb begin
		s_nxt = '0;
		if (rd) begin
			s_nxt.rdata = rv[psel];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
endmodule // gpio_pin_function_select
`default_nettype wire

// ### sim/gpf_pin_model.sv
// pad-side model: device drive, external drivers and pull resistors
`timescale 1ns/1ps
`default_nettype none
module gpf_pin_model (
	input  wire logic        clk,
	input  wire logic [63:0] pin_out,
	input  wire logic [63:0] pin_oe,
	input  wire logic [63:0] pull_up,
	input  wire logic [63:0] pull_down,
	input  wire logic [63:0] ext_val,
	input  wire logic [63:0] ext_drv,
	output logic      [63:0] pin_in
);
	logic flt_r = 1'b0;
	// an undriven, unpulled pad wanders every cycle, so no stale level is trusted
	always @(posedge clk) begin
		flt_r <= ~flt_r;
	end
	// pad level: device first, then the outside driver, then the pulls
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] :
				pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : flt_r;
		end
	end
endmodule // gpf_pin_model
`default_nettype wire

// ### sim/gpio_pin_function_select_tb_top.sv
// self-checking bench for the eight-port gpio block
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_select_tb_top;
	logic        clk;
	logic        rst_n = 1'b0;
	logic [14:0] addr = 15'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [63:0] pin_in, pin_out, pin_oe, pull_up, pull_down, alt_in, ana_en, cmp_en;
	logic [63:0] alt_out = 64'h0;
	logic [63:0] alt_oe = 64'h0;
	logic [63:0] ext_val = 64'h2000; // port B bit 5 held high
	logic [63:0] ext_drv = 64'hFF00; // all of port B driven from outside, no floating edges
	logic [7:0]  port_irq;
	logic        adc_trig;
	logic        last_d = 1'b0;
	int          n_fail = 0;
	int          n_tests = 0;
	int          n_tgl = 0;

	gpio_pin_function_select u_gpio_pin_function_select (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pull_down(pull_down),
		.alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .ana_en(ana_en),
		.cmp_en(cmp_en), .port_irq(port_irq), .adc_trig(adc_trig));
	gpf_pin_model u_gpf_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up(pull_up), .pull_down(pull_down), .ext_val(ext_val), .ext_drv(ext_drv),
		.pin_in(pin_in));

	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// count changes of port D bit 0 between edges
	always @(negedge clk) begin
		if (pin_out[24] !== last_d) n_tgl++;
		last_d = pin_out[24];
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// one write cycle, strobe dropped before the next
	task automatic bw(input logic [2:0] p, input logic [11:0] o, input logic [31:0] d);
		addr <= {p, o};
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// one read cycle, data checked in the cycle after the strobe
	task automatic br(input logic [2:0] p, input logic [11:0] o, input logic [31:0] e,
		input string msg);
		addr <= {p, o};
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e, msg);
		@(posedge clk);
	endtask

	task automatic t_reset;
		br(3'h0, 12'h420, 32'h3F, "afsel a");
		br(3'h1, 12'h51C, 32'h0C, "den b");
		br(3'h0, 12'h52C, 32'h00111111, "pctl a");
		br(3'h2, 12'h510, 32'h0F, "pull c");
		br(3'h2, 12'h52C, 32'h00003333, "pctl c");
		br(3'h3, 12'h420, 32'h0, "afsel d");
		br(3'h4, 12'h52C, 32'h0, "pctl e");
		br(3'h0, 12'h514, 32'h0, "pdr a");
		br(3'h0, 12'h600, 32'h0, "unmapped");
		chk(pull_up[23:16], 32'h0F, "pull_up c");
		chk({31'h0, |pin_oe[63:24]}, 32'h0, "tri-state");
		$display("test reset defaults done");
	endtask

	task automatic t_data;
		int s;
		bw(3'h3, 12'h51C, 32'hFF);
		bw(3'h3, 12'h400, 32'hFF);
		bw(3'h3, 12'h3FC, 32'h0);
		bw(3'h3, 12'h098, 32'hEB);
		br(3'h3, 12'h3FC, 32'h22, "masked write");
		br(3'h3, 12'h0C4, 32'h20, "masked read");
		chk(pin_out[31:24], 32'h22, "pin drive");
		s = n_tgl;
		for (int i = 0; i < 4; i++) bw(3'h3, 12'h004, 32'(~i[0]));
		@(posedge clk);
		chk(32'(n_tgl - s), 32'h4, "toggle rate");
		$display("test data mask done");
	endtask

	task automatic t_alt;
		alt_out[1:0] <= 2'h3;
		alt_oe[1:0] <= 2'h3;
		repeat (4) @(posedge clk);
		#1 chk({pin_oe[1:0], pin_out[1:0]}, 32'hF, "alt drive");
		@(posedge clk);
		bw(3'h0, 12'h52C, 32'h00111110);
		repeat (4) @(posedge clk);
		#1 chk(pin_oe[1:0], 32'h2, "alt deselect");
		chk(alt_in[1:0], 32'h2, "alt input");
		@(posedge clk);
		$display("test alternate routing done");
	endtask

	task automatic t_ana;
		bw(3'h1, 12'h51C, 32'h0);
		bw(3'h1, 12'h528, 32'h10);
		repeat (2) @(posedge clk);
		#1 chk(ana_en[15:8], 32'h10, "analog on");
		chk(cmp_en[15:8], 32'h50, "comparator on");
		@(posedge clk);
		bw(3'h1, 12'h51C, 32'h10);
		repeat (2) @(posedge clk);
		#1 chk(ana_en[15:8], 32'h0, "analog off");
		chk(cmp_en[15:8], 32'h40, "comparator off");
		@(posedge clk);
		$display("test analog paths done");
	endtask

	task automatic t_irq;
		int k;
		bw(3'h1, 12'h51C, 32'h30);
		bw(3'h1, 12'h528, 32'h0);
		bw(3'h1, 12'h404, 32'h20);
		bw(3'h1, 12'h40C, 32'h10);
		bw(3'h1, 12'h410, 32'h10);
		br(3'h1, 12'h414, 32'h0, "quiet status");
		ext_val[13] <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk(port_irq, 32'h0, "masked level");
		ext_val[12] <= 1'b1;
		for (k = 0; k < 10; k++) begin
			@(posedge clk);
			#1 if (adc_trig === 1'b1) break;
		end
		if (k == 10) begin
			chk(32'h0, 32'h1, "no trigger");
			final_report();
		end
		chk(port_irq, 32'h2, "port irq");
		@(posedge clk);
		br(3'h1, 12'h414, 32'h30, "raw status");
		repeat (2) @(posedge clk);
		#1 chk(port_irq, 32'h0, "irq cleared");
		@(posedge clk);
		bw(3'h1, 12'h408, 32'h10);
		ext_val[12] <= 1'b0;
		repeat (5) @(posedge clk);
		br(3'h1, 12'h418, 32'h10, "both edges");
		// switch bit 5 to high level sense while it is low, then raise it
		bw(3'h1, 12'h40C, 32'h30);
		br(3'h1, 12'h414, 32'h30, "status before high level");
		ext_val[13] <= 1'b1;
		repeat (4) @(posedge clk);
		br(3'h1, 12'h414, 32'h20, "high level");
		$display("test interrupts done");
	endtask

	task automatic t_rerst;
		bw(3'h2, 12'h420, 32'h0);
		bw(3'h2, 12'h514, 32'h30);
		#1 chk(pull_down[23:16], 32'h30, "pull_down c");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		br(3'h2, 12'h420, 32'h0F, "afsel c again");
		br(3'h1, 12'h410, 32'h0, "mask again");
		chk(pull_down[23:16], 32'h0, "pull_down c again");
		$display("test second reset done");
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_data();
		t_alt();
		t_ana();
		t_irq();
		t_rerst();
		final_report();
	end
endmodule // gpio_pin_function_select_tb_top
`default_nettype wire
